// file: vlam_monitor.sv
// two-channel vibration limit monitor: scheduling, limit delays, relays, event log
// assumes sensor and operator pins are asynchronous
`timescale 1ns/1ps
module vlam_monitor
	import vlam_pkg::*;
#(
	parameter int unsigned TICK_CYC_P = TICK_CYCLES
)(
	// clock and reset
	input  wire logic            mclk_i,
	input  wire logic            sys_rst_i,
	// channel configuration
	input  wire logic            two_chan_i,
	input  wire logic [4:0]      func_a_i,
	input  wire logic [4:0]      func_b_i,
	input  wire logic [5:0]      lim_active_i,
	input  wire logic [9:0]      vib_range_i,
	input  wire logic [9:0]      bcu_range_i,
	// limit setting port
	input  wire logic            lim_wr_i,
	input  wire logic [2:0]      lim_sel_i,
	input  wire logic [9:0]      lim_val_i,
	input  wire logic [6:0]      lim_dly_i,
	// relay configuration
	input  wire logic [2:0][5:0] rly_map_i,
	input  wire logic [2:0]      rly_and_i,
	input  wire logic [2:0]      rly_latch_i,
	input  wire logic [2:0]      rly_norm_en_i,
	// sensor side
	input  wire logic [9:0]      vib_a_i,
	input  wire logic [9:0]      vib_b_i,
	input  wire logic [9:0]      bcu_a_i,
	input  wire logic [9:0]      bcu_b_i,
	input  wire logic [7:0]      bias_a_i,
	input  wire logic [7:0]      bias_b_i,
	// operator commands
	input  wire logic            relay_reset_i,
	input  wire logic            log_clear_i,
	input  wire logic [6:0]      log_rd_idx_i,
	// relay coils
	output logic                 alarm_relay_one_o,
	output logic                 alarm_relay_two_o,
	output logic                 alarm_relay_three_o,
	output logic                 ok_relay_o,
	// status
	output logic                 lim_err_o,
	output logic [5:0]           alarm_o,
	output logic                 vib_chan_o,
	output logic                 vib_window_o,
	output logic [9:0]           disp_vib_a_o,
	output logic [9:0]           disp_vib_b_o,
	output logic [9:0]           disp_bcu_a_o,
	output logic [9:0]           disp_bcu_b_o,
	// log readout
	output logic [21:0]          log_rd_data_o,
	output logic [6:0]           log_count_o
);
	localparam int PIN_W = 58;

	vlam_log_if lg();

	logic [PIN_W-1:0]   sync1_reg;
	logic [PIN_W-1:0]   sync2_reg;
	logic [9:0]         vib_a, vib_b, bcu_a, bcu_b;
	logic [7:0]         bias_a, bias_b;
	logic               rst_lvl, clr_lvl;
	logic               rst_d_reg, clr_d_reg;
	logic               rst_edge, clr_edge;
	logic [31:0]        tick_cnt_reg;
	logic               tick_reg;
	logic               disp_ph_reg;
	vlam_st_t           vst_reg, bst_reg;
	logic               vch_reg, bch_reg;
	logic [4:0]         vcnt_reg, bcnt_reg;
	logic [1:0]         vwin, bwin;
	logic [9:0]         lim_reg [NUM_LIM];
	logic [6:0]         dly_reg [NUM_LIM];
	logic [8:0]         dcnt_reg [NUM_LIM];
	logic [5:0]         alm_reg, alm_d_reg;
	logic [5:0]         win, above;
	logic [9:0]         val [NUM_LIM];
	logic [1:0]         flt, flt_d_reg;
	logic               fault_any;
	logic               ok_hold_reg;
	logic               rst_pend_reg;
	logic               release_ok;
	logic [2:0]         trip_reg;
	logic [9:0]         ev_pend_reg;
	logic               wr_valid_reg;
	logic [ENTRY_W-1:0] wr_entry_reg;
	logic [6:0]         seq_reg;

	// longest settling time of the selected conditioning functions
	function automatic logic [4:0] settle_tk(input logic [4:0] fn);
		logic [4:0] t;
		t = 5'h00;
		if (fn[FN_HP1]  && SET_HP1_TK  > t) t = SET_HP1_TK;
		if (fn[FN_HP3]  && SET_HP3_TK  > t) t = SET_HP3_TK;
		if (fn[FN_HP10] && SET_HP10_TK > t) t = SET_HP10_TK;
		if (fn[FN_INT]  && SET_INT_TK  > t) t = SET_INT_TK;
		if (fn[FN_LIN]  && SET_LIN_TK  > t) t = SET_LIN_TK;
		return t;
	endfunction

	// limit lies within 10 % .. 100 % of its range
	function automatic logic lim_ok(input logic [9:0] v, input logic [9:0] range);
		logic [16:0] lo_side, hi_side;
		lo_side = 17'(v) * 17'(LIM_MAX_PCT);
		hi_side = 17'(range) * 17'(LIM_MIN_PCT);
		return (lo_side >= hi_side) && (v <= range);
	endfunction

	// AND or OR of the limits assigned to one relay
	function automatic logic relay_cond(input logic [5:0] map, input logic use_and,
					    input logic [5:0] alm);
		if (map == 6'h00) begin
			return 1'b0;
		end
		if (use_and) begin
			return &(alm | ~map);
		end
		return |(alm & map);
	endfunction

	// two flip-flops on every sensor pin and on relay_reset_i and log_clear_i
	always_ff @(posedge mclk_i) begin
		sync1_reg <= {vib_a_i, vib_b_i, bcu_a_i, bcu_b_i, bias_a_i, bias_b_i,
			      relay_reset_i, log_clear_i};
		sync2_reg <= sync1_reg;
	end
	assign {vib_a, vib_b, bcu_a, bcu_b, bias_a, bias_b, rst_lvl, clr_lvl} = sync2_reg;

	// rising edges of the operator commands
	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			rst_d_reg <= 1'b0;
			clr_d_reg <= 1'b0;
		end else begin
			rst_d_reg <= rst_lvl;
			clr_d_reg <= clr_lvl;
		end
	end
	assign rst_edge = rst_lvl && !rst_d_reg;
	assign clr_edge = clr_lvl && !clr_d_reg;

	// comparison tick and display phase
	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			tick_cnt_reg <= 32'h0;
			tick_reg     <= 1'b0;
			disp_ph_reg  <= 1'b0;
		end else if (tick_cnt_reg == TICK_CYC_P - 1) begin
			tick_cnt_reg <= 32'h0;
			tick_reg     <= 1'b1; // R01
			disp_ph_reg  <= (DISP_TICKS == 1) ? 1'b1 : !disp_ph_reg;
		end else begin
			tick_cnt_reg <= tick_cnt_reg + 32'h1;
			tick_reg     <= 1'b0;
		end
	end

	// conditioner: settle, measure, switch channel
	always_ff @(posedge mclk_i) begin
		if (sys_rst_i || !two_chan_i) begin
			vst_reg  <= ST_MEAS; // R01
			vch_reg  <= 1'b0;
			vcnt_reg <= MEAS_WIN_TK;
		end else if (tick_reg) begin
			if (vcnt_reg > 5'h01) begin
				vcnt_reg <= vcnt_reg - 5'h01;
			end else if (vst_reg == ST_SETTLE) begin
				vst_reg  <= ST_MEAS; // R02
				vcnt_reg <= MEAS_WIN_TK;
			end else begin
				vst_reg  <= ST_SETTLE; // R05
				vch_reg  <= !vch_reg;
				vcnt_reg <= settle_tk(vch_reg ? func_a_i : func_b_i); // R03 R04
			end
		end
	end

	// bearing detector runs on its own schedule
	always_ff @(posedge mclk_i) begin
		if (sys_rst_i || !two_chan_i) begin
			bst_reg  <= ST_MEAS;
			bch_reg  <= 1'b0;
			bcnt_reg <= BCU_MEAS_TK;
		end else if (tick_reg) begin
			if (bcnt_reg > 5'h01) begin
				bcnt_reg <= bcnt_reg - 5'h01;
			end else if (bst_reg == ST_SETTLE) begin
				bst_reg  <= ST_MEAS; // R07
				bcnt_reg <= BCU_MEAS_TK;
			end else begin
				bst_reg  <= ST_SETTLE; // R07
				bch_reg  <= !bch_reg;
				bcnt_reg <= BCU_SET_TK;
			end
		end
	end

	// measurement windows per channel and per limit
	assign vwin[0] = (vst_reg == ST_MEAS) && !vch_reg;
	assign vwin[1] = (vst_reg == ST_MEAS) && vch_reg;
	assign bwin[0] = (bst_reg == ST_MEAS) && !bch_reg;
	assign bwin[1] = (bst_reg == ST_MEAS) && bch_reg;
	assign win     = {bwin[1], vwin[1], vwin[1], bwin[0], vwin[0], vwin[0]};
	assign val[0]  = vib_a;
	assign val[1]  = vib_a;
	assign val[2]  = bcu_a;
	assign val[3]  = vib_b;
	assign val[4]  = vib_b;
	assign val[5]  = bcu_b;

	// displays refresh in their window, frozen outside it
	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			disp_vib_a_o <= 10'h000;
			disp_vib_b_o <= 10'h000;
			disp_bcu_a_o <= 10'h000;
			disp_bcu_b_o <= 10'h000;
		end else if (tick_reg && (two_chan_i || disp_ph_reg)) begin
			if (vwin[0]) disp_vib_a_o <= vib_a; // R01
			if (vwin[1]) disp_vib_b_o <= vib_b; // R06
			if (bwin[0]) disp_bcu_a_o <= bcu_a;
			if (bwin[1]) disp_bcu_b_o <= bcu_b;
		end
	end

	// limit and delay setting with range check
	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			lim_err_o <= 1'b0;
			for (int i = 0; i < NUM_LIM; i++) begin
				lim_reg[i] <= LIM_RST; // R08
				dly_reg[i] <= DLY_RST;
			end
		end else if (lim_wr_i) begin
			if (lim_sel_i < 3'(NUM_LIM)
			    && lim_ok(lim_val_i, (lim_sel_i == 3'h2 || lim_sel_i == 3'h5)
					? bcu_range_i : vib_range_i)
			    && lim_dly_i >= DLY_MIN_S && lim_dly_i <= DLY_MAX_S) begin
				lim_reg[lim_sel_i] <= lim_val_i; // R08
				dly_reg[lim_sel_i] <= lim_dly_i; // R10
				lim_err_o          <= 1'b0;
			end else begin
				lim_err_o <= 1'b1; // R09
			end
		end
	end

	// alarm delay counts in-window ticks above the limit
	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			alm_reg <= 6'h00;
			for (int i = 0; i < NUM_LIM; i++) begin
				dcnt_reg[i] <= 9'h000;
			end
		end else begin
			for (int i = 0; i < NUM_LIM; i++) begin
				if (!lim_active_i[i] || (!two_chan_i && i >= LIM_KINDS)) begin
					dcnt_reg[i] <= 9'h000; // R20
					alm_reg[i]  <= 1'b0;
				end else if (tick_reg && win[i]) begin // R06 R11
					if (!above[i]) begin
						dcnt_reg[i] <= 9'h000; // R17
						alm_reg[i]  <= 1'b0;
					end else if (dcnt_reg[i] >= 9'(dly_reg[i]) * 9'(TICKS_PER_S)) begin
						alm_reg[i] <= 1'b1; // R10
					end else begin
						dcnt_reg[i] <= dcnt_reg[i] + 9'h001;
					end
				end
			end
		end
	end
	always_comb begin
		for (int i = 0; i < NUM_LIM; i++) begin
			above[i] = val[i] > lim_reg[i];
		end
	end

	// line faults from the sensor bias leaving its window
	assign flt[0]    = bias_a < BIAS_LO || bias_a > BIAS_HI; // R21
	assign flt[1]    = two_chan_i && (bias_b < BIAS_LO || bias_b > BIAS_HI);
	assign fault_any = |flt;
	assign release_ok = !fault_any && rst_pend_reg;

	// reset request held to the next tick; set wins
	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			rst_pend_reg <= 1'b0;
		end else if (rst_edge) begin
			rst_pend_reg <= 1'b1;
		end else if (tick_reg) begin
			rst_pend_reg <= 1'b0;
		end
	end

	// health hold: set by fault, freed by a later reset
	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			ok_hold_reg <= 1'b0;
		end else if (fault_any) begin
			ok_hold_reg <= 1'b1; // R22
		end else if (tick_reg && release_ok) begin
			ok_hold_reg <= 1'b0; // R22
		end
	end

	// relay trip state evaluated at each tick with no fault or health hold standing
	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			trip_reg <= 3'h0;
		end else if (tick_reg && !(ok_hold_reg && !release_ok) && !fault_any) begin
			for (int r = 0; r < 3; r++) begin
				if (rly_latch_i[r]) begin
					trip_reg[r] <= relay_cond(rly_map_i[r], rly_and_i[r], alm_reg)
						       || (trip_reg[r] && !rst_pend_reg); // R16 R23
				end else begin
					trip_reg[r] <= relay_cond(rly_map_i[r], rly_and_i[r], alm_reg); // R17 R19
				end
			end
		end
	end

	// coil drive with polarity; health relay normally energized
	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			alarm_relay_one_o   <= 1'b0;
			alarm_relay_two_o   <= 1'b0;
			alarm_relay_three_o <= 1'b0;
			ok_relay_o          <= 1'b0;
		end else begin
			alarm_relay_one_o   <= trip_reg[0] ^ rly_norm_en_i[0]; // R18
			alarm_relay_two_o   <= trip_reg[1] ^ rly_norm_en_i[1];
			alarm_relay_three_o <= trip_reg[2] ^ rly_norm_en_i[2];
			ok_relay_o          <= !(fault_any || ok_hold_reg); // R21
		end
	end

	// edge history for event capture
	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			alm_d_reg <= 6'h00;
			flt_d_reg <= 2'h0;
		end else begin
			alm_d_reg <= alm_reg;
			flt_d_reg <= flt;
		end
	end

	// pending events, one written per cycle, power-up first, then lowest index
	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			ev_pend_reg  <= 10'h200; // R13
			wr_valid_reg <= 1'b0;
			wr_entry_reg <= '0;
			seq_reg      <= 7'h00;
		end else begin
			logic [9:0]  pend;
			logic        found;
			logic [1:0]  rly;
			pend  = ev_pend_reg | {1'b0, rst_edge, flt & ~flt_d_reg, alm_reg & ~alm_d_reg};
			found = 1'b0;
			rly   = 2'h0;
			wr_valid_reg <= 1'b0;
			for (int i = 9; i >= 0; i--) begin
				if (pend[i]) begin
					found = 1'b1;
				end
			end
			if (clr_edge) begin
				seq_reg <= 7'h00; // R15
			end else if (found) begin
				wr_valid_reg <= 1'b1; // R12
				seq_reg      <= (seq_reg == SEQ_LAST) ? 7'h00 : seq_reg + 7'h01;
				if (pend[9]) begin
					pend[9] = 1'b0;
					wr_entry_reg <= {seq_reg, EV_POWER, 5'h00};
				end else if (|pend[5:0]) begin
					for (int i = NUM_LIM - 1; i >= 0; i--) begin
						if (pend[i]) begin
							rly = 2'h0;
							for (int r = 2; r >= 0; r--) begin
								if (rly_map_i[r][i]) rly = 2'(r + 1);
							end
							wr_entry_reg <= {seq_reg, EV_LIMIT, rly, 2'(i % LIM_KINDS),
									 1'(i / LIM_KINDS)}; // R14
						end
					end
					for (int i = 0; i < NUM_LIM; i++) begin
						if (pend[i] && pend[5:0] == (pend[5:0] & (6'h3F << i))) begin
							pend[i] = 1'b0;
						end
					end
				end else if (|pend[7:6]) begin
					wr_entry_reg <= {seq_reg, EV_FAULT, 4'h0, !pend[6]}; // R21
					if (pend[6]) pend[6] = 1'b0;
					else pend[7] = 1'b0;
				end else begin
					pend[8] = 1'b0;
					wr_entry_reg <= {seq_reg, EV_RESET, 5'h00};
				end
			end
			ev_pend_reg <= pend;
		end
	end

	// log store; readout gets the history letter
	assign lg.wr_valid = wr_valid_reg;
	assign lg.wr_entry = wr_entry_reg;
	assign lg.clear    = clr_edge; // R15
	assign lg.rd_idx   = log_rd_idx_i;

	vlam_event_log u_log (
		.mclk_i    (mclk_i),
		.sys_rst_i (sys_rst_i),
		.lg        (lg.store)
	);

	// status outputs
	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			log_rd_data_o <= 22'h0;
			log_count_o   <= 7'h00;
			alarm_o       <= 6'h00;
			vib_chan_o    <= 1'b0;
			vib_window_o  <= 1'b0;
		end else begin
			log_rd_data_o <= {LOG_PREFIX, lg.rd_entry}; // R14
			log_count_o   <= lg.count;
			alarm_o       <= alm_reg;
			vib_chan_o    <= vch_reg;
			vib_window_o  <= vst_reg == ST_MEAS;
		end
	end
endmodule

// file: vlam_pkg.sv
// constants, types and a helper function of the vibration limit alarm monitor
// assumes one 250 MHz clock and a divided quarter-second tick
// How it works
// R01 - single channel: measure continuously, display every 0.5 s, compare every 0.25 s
// R02 - two channels: alternate conditioner A/B, settle, then 3 s measurement window
// R03 - settling: hp1 1.75 s, hp3 1.00 s, hp10 1.25 s, integ 6 s, lin 5.75 s
// R04 - several functions active: the longest settling time applies
// R05 - per-channel setup; full cycle is the sum of both channel cycles
// R06 - other channel's display frozen; measured value still checked every 0.25 s
// R07 - bearing path runs independently: 2.75 s settling, 1.25 s window
// R08 - each channel holds limit one, limit two and a bearing limit
// R09 - limits accepted only within 10..100 % of range, else error flag
// R10 - delay 1..99 s; alarm only when above limit longer than delay; logged, drives relays
// R11 - two-channel mode: delay counts only inside own window, pauses, then resumes
// R12 - circular log of 99 entries; when full the oldest entry drops out
// R13 - logged events: power-up, limit alarm, reset command, sensor line fault
// R14 - entry carries history letter, running two-digit number and event code
// R15 - log cleared at power-up and on a clear request
// R16 - latching relay stays tripped until a reset arrives
// R17 - non-latching relay returns once the value falls below the limit
// R18 - polarity: normally energized drops on alarm, de-energized pulls in on alarm
// R19 - each relay driven by AND or OR of its assigned limits
// R20 - inactive limit never exceeded, so AND relays using it never trip
// R21 - line faults found by bias out of range, shown on health relay and logged
// R22 - while a fault stands limit relays freeze until cleared and reset
// R23 - relays evaluated each tick; latch released only if its condition is gone
package vlam_pkg;
	// clock and comparison tick
	localparam int unsigned CLK_PERIOD_PS = 4000;
	localparam int unsigned TICK_TIME_MS  = 250;
	localparam int unsigned TICK_CYCLES   =
		int'(64'(TICK_TIME_MS) * 64'd1000000000 / 64'(CLK_PERIOD_PS));
	localparam int unsigned DISP_TIME_MS  = 500;
	localparam int unsigned DISP_TICKS    = DISP_TIME_MS / TICK_TIME_MS;
	localparam int unsigned TICKS_PER_S   = 1000 / TICK_TIME_MS;

	// least times round up to whole ticks
	function automatic logic [4:0] ms2tick(input int unsigned ms);
		return 5'((ms + TICK_TIME_MS - 1) / TICK_TIME_MS);
	endfunction

	// vibration conditioner timing
	localparam int unsigned MEAS_WIN_MS = 3000;
	localparam int unsigned SET_HP1_MS  = 1750;
	localparam int unsigned SET_HP3_MS  = 1000;
	localparam int unsigned SET_HP10_MS = 1250;
	localparam int unsigned SET_INT_MS  = 6000;
	localparam int unsigned SET_LIN_MS  = 5750;
	localparam logic [4:0]  MEAS_WIN_TK = ms2tick(MEAS_WIN_MS);
	localparam logic [4:0]  SET_HP1_TK  = ms2tick(SET_HP1_MS);
	localparam logic [4:0]  SET_HP3_TK  = ms2tick(SET_HP3_MS);
	localparam logic [4:0]  SET_HP10_TK = ms2tick(SET_HP10_MS);
	localparam logic [4:0]  SET_INT_TK  = ms2tick(SET_INT_MS);
	localparam logic [4:0]  SET_LIN_TK  = ms2tick(SET_LIN_MS);

	// bearing condition path timing
	localparam int unsigned BCU_SET_MS  = 2750;
	localparam int unsigned BCU_MEAS_MS = 1250;
	localparam logic [4:0]  BCU_SET_TK  = ms2tick(BCU_SET_MS);
	localparam logic [4:0]  BCU_MEAS_TK = ms2tick(BCU_MEAS_MS);

	// conditioning function select bit positions
	localparam int FN_HP1  = 0;
	localparam int FN_HP3  = 1;
	localparam int FN_HP10 = 2;
	localparam int FN_INT  = 3;
	localparam int FN_LIN  = 4;

	// limits: index = channel * 3 + kind (0 limit one, 1 limit two, 2 bearing)
	localparam int          NUM_LIM     = 6;
	localparam int          LIM_KINDS   = 3;
	localparam int unsigned LIM_MIN_PCT = 10;
	localparam int unsigned LIM_MAX_PCT = 100;
	localparam logic [6:0]  DLY_MIN_S   = 7'h01;
	localparam logic [6:0]  DLY_MAX_S   = 7'h63;
	localparam logic [9:0]  LIM_RST     = 10'h3E7;
	localparam logic [6:0]  DLY_RST     = 7'h01;

	// sensor bias window for line fault detection
	localparam logic [7:0] BIAS_LO = 8'h20;
	localparam logic [7:0] BIAS_HI = 8'hE0;

	// event log
	localparam int         LOG_DEPTH  = 99;
	localparam logic [6:0] SEQ_LAST   = 7'h63;
	localparam logic [7:0] LOG_PREFIX = 8'h48;
	localparam int         ENTRY_W    = 14;

	typedef enum logic [1:0] {EV_POWER, EV_LIMIT, EV_RESET, EV_FAULT} vlam_ev_t;
	typedef enum logic {ST_SETTLE, ST_MEAS} vlam_st_t;
endpackage

// file: vlam_log_if.sv
// link between the monitor core and its event log store
// assumes both ends run on the same clock
`timescale 1ns/1ps
interface vlam_log_if;
	import vlam_pkg::*;
	logic               wr_valid;
	logic [ENTRY_W-1:0] wr_entry;
	logic               clear;
	logic [6:0]         rd_idx;
	logic [ENTRY_W-1:0] rd_entry;
	logic [6:0]         count;
	modport ctrl  (output wr_valid, wr_entry, clear, rd_idx, input rd_entry, count);
	modport store (input wr_valid, wr_entry, clear, rd_idx, output rd_entry, count);
endinterface

// file: vlam_event_log.sv
// circular 99-entry event log; read index 0 is the oldest
// assumes at most one write per cycle
`timescale 1ns/1ps
module vlam_event_log
	import vlam_pkg::*;
(
	// clock and reset
	input  wire logic  mclk_i,
	input  wire logic  sys_rst_i,
	// log port
	vlam_log_if.store  lg
);
	logic [ENTRY_W-1:0] mem [LOG_DEPTH];
	logic [6:0]         head_reg;
	logic [6:0]         count_reg;
	logic               full;

	// modulo-depth add, both operands below the depth
	function automatic logic [6:0] wrap_add(input logic [6:0] a, input logic [6:0] b);
		logic [7:0] s;
		s = {1'b0, a} + {1'b0, b};
		if (s >= 8'(LOG_DEPTH)) begin
			s = s - 8'(LOG_DEPTH);
		end
		return s[6:0];
	endfunction

	assign full = (count_reg == 7'(LOG_DEPTH));

	// store; when full the oldest slot is reused
	always_ff @(posedge mclk_i) begin
		if (lg.wr_valid && !lg.clear) begin
			mem[wrap_add(head_reg, full ? 7'h00 : count_reg)] <= lg.wr_entry; // R12
		end
	end

	// oldest pointer and fill level
	always_ff @(posedge mclk_i) begin
		if (sys_rst_i || lg.clear) begin
			head_reg  <= 7'h00; // R15
			count_reg <= 7'h00;
		end else if (lg.wr_valid) begin
			if (full) begin
				head_reg <= wrap_add(head_reg, 7'h01); // R12
			end else begin
				count_reg <= count_reg + 7'h01;
			end
		end
	end

	// registered read, empty slots read as zero
	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			lg.rd_entry <= '0;
		end else if (lg.rd_idx < count_reg) begin
			lg.rd_entry <= mem[wrap_add(head_reg, lg.rd_idx)];
		end else begin
			lg.rd_entry <= '0;
		end
	end

	assign lg.count = count_reg;
endmodule

// file: vlam_chk.sv
// port assertions of the limit monitor
// assumes one clock and the synchronous active-high reset
`timescale 1ns/1ps
module vlam_chk (
	// watched ports
	input wire logic       mclk_i,
	input wire logic       sys_rst_i,
	input wire logic       two_chan_i,
	input wire logic [5:0] lim_active_i,
	input wire logic [9:0] vib_range_i,
	input wire logic       lim_wr_i,
	input wire logic [2:0] lim_sel_i,
	input wire logic [9:0] lim_val_i,
	input wire logic [6:0] lim_dly_i,
	input wire logic       log_clear_i,
	input wire logic       alarm_relay_one_o,
	input wire logic       alarm_relay_two_o,
	input wire logic       alarm_relay_three_o,
	input wire logic       ok_relay_o,
	input wire logic       lim_err_o,
	input wire logic [5:0] alarm_o,
	input wire logic       vib_chan_o,
	input wire logic       vib_window_o,
	input wire logic [6:0] log_count_o
);
	logic ok_a;
	default clocking @(posedge mclk_i); endclocking
	default disable iff (sys_rst_i);
	// a first limit of channel A inside span and delay range
	assign ok_a = lim_val_i <= vib_range_i && lim_dly_i != 7'h00 && lim_dly_i <= 7'h63
		&& 17'(lim_val_i) * 17'h64 >= 17'(vib_range_i) * 17'hA;
	// limit writes
	property p_bad_sel; lim_wr_i && lim_sel_i > 3'h5 |=> lim_err_o; endproperty
	a_bad_sel: assert property (p_bad_sel) else $error("bad index taken");
	property p_reject; lim_wr_i && lim_sel_i == 3'h0 && !ok_a |=> lim_err_o; endproperty
	a_reject: assert property (p_reject) else $error("bad limit taken");
	property p_accept; lim_wr_i && lim_sel_i == 3'h0 && ok_a |=> !lim_err_o; endproperty
	a_accept: assert property (p_accept) else $error("good limit refused");
	// alarms, log, relays and single-channel schedule
	property p_idle; !lim_active_i[1] [*3] |-> !alarm_o[1]; endproperty
	a_idle: assert property (p_idle) else $error("inactive limit alarmed");
	property p_clear; $rose(log_clear_i) |-> ##[1:6] log_count_o == 7'h00; endproperty
	a_clear: assert property (p_clear) else $error("log not cleared");
	property p_count; log_count_o <= 7'h63 && log_count_o <= $past(log_count_o) + 7'h01; endproperty
	a_count: assert property (p_count) else $error("log count jump");
	property p_freeze;
		!ok_relay_o [*3] |-> $stable({alarm_relay_one_o, alarm_relay_two_o, alarm_relay_three_o});
	endproperty
	a_freeze: assert property (p_freeze) else $error("relay moved in fault");
	property p_single; !two_chan_i [*8] |-> vib_window_o && !vib_chan_o; endproperty
	a_single: assert property (p_single) else $error("single mode paused");
endmodule
bind vlam_monitor vlam_chk u_chk (.*);

// file: vlam_far_model.sv
// far side: sensor lines and operator buttons
// assumes bench levels; changes at the falling edge
`timescale 1ns/1ps
module vlam_far_model (
	// clock and bench levels
	input  wire logic       mclk_i,
	input  wire logic [9:0] lvl_i,
	input  wire logic       cut_i,
	// sensor lines and buttons
	output logic [9:0]      vib_o = 10'h000,
	output logic [7:0]      bias_o = 8'h80,
	output logic            rst_btn_o = 1'h0,
	output logic            clr_btn_o = 1'h0
);
	// a cut cable grounds the bias line
	always @(negedge mclk_i) begin
		vib_o <= lvl_i;
		bias_o <= cut_i ? 8'h00 : 8'h80;
	end
	// one press: 4 cycles held, 4 low
	task automatic press(input logic clr);
		@(negedge mclk_i);
		if (clr) clr_btn_o = 1'h1;
		else rst_btn_o = 1'h1;
		repeat (4) @(negedge mclk_i);
		clr_btn_o = 1'h0;
		rst_btn_o = 1'h0;
		repeat (4) @(negedge mclk_i);
	endtask
endmodule

// file: tb_vibration_limit_alarm_monitor.sv
// self-checking bench of the limit monitor
// assumes a 20-cycle tick
`timescale 1ns/1ps
module tb_vibration_limit_alarm_monitor;
	localparam int TK = 20;
	logic            mclk_i = 1'h0, sys_rst_i = 1'h1, two_chan_i = 1'h0, lim_wr_i = 1'h0, cut = 1'h0;
	logic [2:0]      lim_sel_i = 3'h0, rly_and_i = 3'h4, rly_latch_i = 3'h2, rly_norm_en_i = 3'h1;
	logic [9:0]      lim_val_i = 10'h000, vib_range_i = 10'h064, bcu_range_i = 10'h0C8, lvl = 10'h000;
	logic [6:0]      lim_dly_i = 7'h00, log_rd_idx_i = 7'h00, log_count_o;
	logic [4:0]      func_a_i = 5'h01, func_b_i = 5'h0A;
	logic [5:0]      lim_active_i = 6'h01, alarm_o;
	logic [2:0][5:0] rly_map_i = {6'h03, 6'h01, 6'h01};
	logic [9:0]      vib;
	logic [7:0]      bias;
	logic            rst_btn, clr_btn, r1, r2, r3, ok, lim_err_o, vib_chan_o, vib_window_o, win_a;
	logic [21:0]     log_rd_data_o;
	logic [3:0]      cl;
	int              num_errors = 0, compares = 0, seed = 91, k, n, sq = 0;
	int              q[$];
	// design and far side
	vlam_monitor #(.TICK_CYC_P(TK)) u_dut (.mclk_i, .sys_rst_i, .two_chan_i, .func_a_i, .func_b_i,
		.lim_active_i, .vib_range_i, .bcu_range_i, .lim_wr_i, .lim_sel_i, .lim_val_i, .lim_dly_i,
		.rly_map_i, .rly_and_i, .rly_latch_i, .rly_norm_en_i, .vib_a_i(vib), .vib_b_i(vib),
		.bcu_a_i(vib), .bcu_b_i(vib), .bias_a_i(bias), .bias_b_i(bias), .relay_reset_i(rst_btn),
		.log_clear_i(clr_btn), .log_rd_idx_i, .alarm_relay_one_o(r1), .alarm_relay_two_o(r2),
		.alarm_relay_three_o(r3), .ok_relay_o(ok), .lim_err_o, .alarm_o, .vib_chan_o,
		.vib_window_o, .disp_vib_a_o(), .disp_vib_b_o(), .disp_bcu_a_o(), .disp_bcu_b_o(),
		.log_rd_data_o, .log_count_o);
	vlam_far_model u_far (.mclk_i, .lvl_i(lvl), .cut_i(cut), .vib_o(vib), .bias_o(bias),
		.rst_btn_o(rst_btn), .clr_btn_o(clr_btn));
	assign win_a = vib_window_o === 1'h1 && vib_chan_o === 1'h0;
	assign cl = {ok, r3, r2, r1};
	// clock
	initial forever #2 mclk_i = ~mclk_i;
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e) begin
			num_errors++;
			$display("[FAIL] %s expected %0h seen %0h", nm, e, g);
		end
	endtask
	task automatic tk(input int t);
		repeat (t * TK) @(negedge mclk_i);
	endtask
	task automatic cy(input int n);
		repeat (n) @(negedge mclk_i);
	endtask
	// log model: seq*4+type, capped at 99
	task automatic lg(input int t);
		q.push_back(sq * 4 + t);
		sq = (sq + 1) % 100;
		if (q.size() > 99) q.pop_front();
	endtask
	// one limit write
	task automatic wr(input logic [2:0] s, input logic [9:0] v, input logic [6:0] d);
		int r;
		r = (s == 3'h2 || s == 3'h5) ? bcu_range_i : vib_range_i;
		lim_wr_i = 1'h1;
		lim_sel_i = s;
		lim_val_i = v;
		lim_dly_i = d;
		cy(1);
		lim_wr_i = 1'h0;
		cy(1);
		chk("lim_err", s > 5 || v * 100 < r * 10 || v > r || d < 1 || d > 99, lim_err_o);
	endtask
	task automatic end_sim();
		$display("compares %0d num_errors %0d", compares, num_errors);
		if (num_errors == 0 && compares > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	// watchdog
	initial begin
		repeat (100000) @(posedge mclk_i);
		num_errors++;
		end_sim();
	end
	// main sequence
	initial begin
		cy(6);
		sys_rst_i = 1'h0;
		lg(0);
		cy(30);
		chk("count", q.size(), log_count_o);
		chk("entry", {8'h48, 9'h000}, log_rd_data_o[21:5]);
		chk("coils", 4'h9, cl);
		$display("power-up test done");
		wr(3'h0, 10'h009, 7'h01);
		wr(3'h0, 10'h00A, 7'h01);
		wr(3'h0, 10'h065, 7'h01);
		wr(3'h3, 10'h064, 7'h63);
		wr(3'h1, 10'h032, 7'h00);
		wr(3'h0, 10'h032, 7'h64);
		for (int i = 0; i < 20; i++) wr(3'($random(seed)), 10'($random(seed)), 7'($random(seed)));
		wr(3'h0, 10'h032, 7'h01);
		$display("limit test done");
		lvl = 10'h050;
		tk(3);
		chk("early", 1'h0, alarm_o[0]);
		for (k = 0; k < 4 * TK && alarm_o[0] !== 1'h1; k++) cy(1);
		chk("alarm", 1'h1, alarm_o[0]);
		tk(2);
		chk("coils", 4'hA, cl);
		lg(1);
		chk("count", q.size(), log_count_o);
		lvl = 10'h00A;
		tk(3);
		chk("coils", 4'hB, cl);
		u_far.press(1'h0);
		lg(2);
		tk(3);
		chk("coils", 4'h9, cl);
		chk("count", q.size(), log_count_o);
		$display("relay test done");
		cut = 1'h1;
		tk(2);
		chk("fault", 4'h1, cl);
		lvl = 10'h050;
		tk(8);
		chk("frozen", 4'h1, cl);
		cut = 1'h0;
		tk(2);
		chk("held", 4'h1, cl);
		u_far.press(1'h0);
		tk(3);
		chk("resumed", 4'hA, cl);
		lvl = 10'h00A;
		tk(3);
		$display("fault test done");
		u_far.press(1'h1);
		q.delete();
		sq = 0;
		chk("cleared", 7'h00, log_count_o);
		for (int i = 0; i < 101; i++) begin
			u_far.press(1'h0);
			lg(2);
			tk(1);
		end
		chk("full", q.size(), log_count_o);
		chk("oldest", q[0], log_rd_data_o[13:5]);
		log_rd_idx_i = 7'h62;
		cy(3);
		chk("newest", q[98], log_rd_data_o[13:5]);
		$display("log test done");
		sys_rst_i = 1'h1;
		two_chan_i = 1'h1;
		cy(6);
		sys_rst_i = 1'h0;
		repeat (2) begin
			for (k = 0; k < 3000 && !win_a; k++) cy(1);
			for (k = 0; k < 3000 && win_a; k++) cy(1);
		end
		chk("window", 12 * TK, k);
		for (n = k; n < 3000 && !win_a; n++) cy(1);
		chk("cycle", 55 * TK, n);
		$display("schedule test done");
		end_sim();
	end
endmodule
